// >>> hdl/fpb_pkg.sv
// package: constants for the flash page buffer and status block
package fpb_pkg;
	// completion status codes
	localparam logic [1:0] FPB_ST_OK      = 2'h0;
	localparam logic [1:0] FPB_ST_ONE     = 2'h1;
	localparam logic [1:0] FPB_ST_TWO     = 2'h2;
	localparam logic [1:0] FPB_ST_THREE   = 2'h3;
	// operation codes on op_code
	localparam logic [2:0] FPB_OP_READ    = 3'h0;
	localparam logic [2:0] FPB_OP_UNPROT  = 3'h1;
	localparam logic [2:0] FPB_OP_WRITE   = 3'h2;
	localparam logic [2:0] FPB_OP_ERASE   = 3'h3;
	localparam logic [2:0] FPB_OP_PROGRAM = 3'h4;
	// register byte offsets
	localparam logic [7:0] FPB_REG_STATUS = 8'h00;
	localparam logic [7:0] FPB_REG_IRQ_ST = 8'h04;
	localparam logic [7:0] FPB_REG_IRQ_MK = 8'h08;
	localparam logic [7:0] FPB_REG_PAGE   = 8'h0c;
	localparam logic [7:0] FPB_REG_LIMIT  = 8'h10;
	localparam logic [7:0] FPB_REG_PROT   = 8'h14;
	// reset values and axi response codes
	localparam logic [15:0] FPB_LIMIT_RST = 16'h2710;
	localparam logic [1:0]  FPB_RESP_OK   = 2'h0;
	localparam logic [1:0]  FPB_RESP_ERR  = 2'h2;
	// interrupt status bit positions
	localparam int FPB_IRQ_DONE = 0;
	localparam int FPB_IRQ_ERR  = 1;
	// fsm states
	typedef enum logic [2:0] {
		FPB_IDLE = 3'b001,
		FPB_LOAD = 3'b010,
		FPB_DONE = 3'b100
	} fpb_state_e;
endpackage : fpb_pkg

// >>> hdl/fpb_top.sv
// flash page buffer, operation status and axi4-lite control registers
// Overview of operation
// - status output holds two-bit result of last finished operation, 00 means success
// - read or unlock-load reports 01 for corrected single error, 10 for multiple
// - write reports 01 on protected page, 11 on other page before program
// - erase protection violation or program of unmodified/protected buffer report 01
// - erase or program report 11 when page write count reaches retention limit
// - unlock-load copies addressed page into buffer, then makes buffer writable
// - write strobe stores 32-bit write word into the page buffer
`timescale 1ns/1ps
module fpb_top
	import fpb_pkg::*;
#(
	parameter int WORDS = 32,
	parameter int AW    = 5,
	parameter int PAGES = 16,
	parameter int PW    = 4
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// user operation port
	input  wire logic             op_start,
	input  wire logic [2:0]       op_code,
	input  wire logic [PW-1:0]    page_addr,
	input  wire logic [AW-1:0]    word_addr,
	input  wire logic             page_unlock_load,
	input  wire logic             write_strobe,
	input  wire logic [31:0]      write_word_in,
	input  wire logic [31:0]      array_word,
	input  wire logic             ecc_single,
	input  wire logic             ecc_multi,
	output logic [1:0]            op_status,
	output logic                  op_busy,
	output logic                  op_done,
	output logic [31:0]           read_word,
	output logic [AW-1:0]         array_addr,
	// axi4-lite slave
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	// interrupt
	output logic                  irq
);

	// page buffer storage and bookkeeping
	logic [31:0]        buf_mem [WORDS];
	logic [PW-1:0]      buf_page_reg;
	logic               buf_valid_reg;
	logic               buf_writable_reg;
	logic               buf_dirty_reg;
	logic [15:0]        wcount_mem [PAGES];
	logic [PAGES-1:0]   prot_reg;
	logic [15:0]        limit_reg;
	logic [1:0]         irq_st_reg;
	logic [1:0]         irq_mk_reg;
	fpb_state_e         state_reg;
	logic [AW-1:0]      load_cnt_reg;
	logic [1:0]         load_err_reg;
	logic [1:0]         result;
	logic               finish;
	logic               is_imm;

	// merge two ecc levels into a status code, multi-error wins
	function automatic logic [1:0] ecc_code(input logic single, input logic multi);
		if (multi)
			return FPB_ST_TWO;
		else if (single)
			return FPB_ST_ONE;
		else
			return FPB_ST_OK;
	endfunction : ecc_code

	// immediate operations finish in the cycle after op_start; unlock-load walks the page
	assign is_imm = op_start && state_reg == FPB_IDLE && !page_unlock_load;

	// result of an immediate operation, decided from the live inputs
	always_comb begin
		result = FPB_ST_OK;
		case (op_code)
			FPB_OP_READ: result = ecc_code(ecc_single, ecc_multi);
			FPB_OP_WRITE: begin
				if (prot_reg[page_addr])
					result = FPB_ST_ONE;
				else if (buf_dirty_reg && buf_page_reg != page_addr)
					result = FPB_ST_THREE;
			end
			FPB_OP_ERASE: begin
				if (prot_reg[page_addr])
					result = FPB_ST_ONE;
				else if (wcount_mem[page_addr] >= limit_reg)
					result = FPB_ST_THREE;
			end
			FPB_OP_PROGRAM: begin
				if (!buf_dirty_reg || prot_reg[buf_page_reg])
					result = FPB_ST_ONE;
				else if (wcount_mem[buf_page_reg] >= limit_reg)
					result = FPB_ST_THREE;
			end
			default: result = FPB_ST_OK;
		endcase
	end

	// unlock-load sequencer: one array word per cycle into the buffer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg    <= FPB_IDLE;
			load_cnt_reg <= '0;
			load_err_reg <= FPB_ST_OK;
		end else begin
			case (state_reg)
				FPB_IDLE: begin
					if (page_unlock_load) begin
						state_reg    <= FPB_LOAD;
						load_cnt_reg <= '0;
						load_err_reg <= FPB_ST_OK;
					end
				end
				FPB_LOAD: begin
					if (ecc_multi || load_err_reg == FPB_ST_TWO)
						load_err_reg <= FPB_ST_TWO;
					else
						load_err_reg <= load_err_reg | ecc_code(ecc_single, 1'b0);
					load_cnt_reg <= load_cnt_reg + 1'b1;
					if (load_cnt_reg == AW'(WORDS - 1))
						state_reg <= FPB_DONE;
				end
				FPB_DONE: state_reg <= FPB_IDLE;
				default:  state_reg <= FPB_IDLE;
			endcase
		end
	end

	assign finish = is_imm || state_reg == FPB_DONE;

	// buffer contents: loaded from array, or written by the strobe once writable
	always_ff @(posedge aclk) begin
		if (state_reg == FPB_LOAD)
			buf_mem[load_cnt_reg] <= array_word;
		else if (write_strobe && buf_writable_reg)
			buf_mem[word_addr] <= write_word_in;
	end

	// buffer ownership flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			buf_page_reg     <= '0;
			buf_valid_reg    <= 1'b0;
			buf_writable_reg <= 1'b0;
			buf_dirty_reg    <= 1'b0;
		end else if (state_reg == FPB_IDLE && page_unlock_load) begin
			buf_page_reg     <= page_addr;
			buf_valid_reg    <= 1'b0;
			buf_writable_reg <= 1'b0;
			buf_dirty_reg    <= 1'b0;
		end else if (state_reg == FPB_DONE) begin
			buf_valid_reg    <= 1'b1;
			buf_writable_reg <= 1'b1;
		end else if (write_strobe && buf_writable_reg && state_reg == FPB_IDLE) begin
			buf_dirty_reg    <= 1'b1;
		end else if (is_imm && op_code == FPB_OP_PROGRAM && result != FPB_ST_ONE) begin
			buf_dirty_reg    <= 1'b0;
		end
	end

	// per-page write counters bump on every erase or program that does not report 01, even one reporting 11 at the limit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < PAGES; i++)
				wcount_mem[i] <= '0;
		end else if (is_imm && op_code == FPB_OP_ERASE && !prot_reg[page_addr]) begin
			wcount_mem[page_addr] <= wcount_mem[page_addr] + 16'h0001;
		end else if (is_imm && op_code == FPB_OP_PROGRAM && result != FPB_ST_ONE) begin
			wcount_mem[buf_page_reg] <= wcount_mem[buf_page_reg] + 16'h0001;
		end
	end

	// status output and completion pulse; status stays put between completions
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_status <= FPB_ST_OK;
			op_done   <= 1'b0;
			read_word <= '0;
		end else begin
			op_done <= finish;
			if (is_imm)
				op_status <= result;
			else if (state_reg == FPB_DONE)
				op_status <= load_err_reg;
			if (is_imm && op_code == FPB_OP_READ)
				read_word <= array_word;
		end
	end

	// busy and array address; the address leads the walk since the array answers a cycle late
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_busy    <= 1'b0;
			array_addr <= '0;
		end else begin
			op_busy    <= (state_reg == FPB_IDLE && page_unlock_load) || state_reg == FPB_LOAD;
			array_addr <= (state_reg == FPB_LOAD) ? load_cnt_reg + AW'(2)
				: ((state_reg == FPB_IDLE && page_unlock_load) ? AW'(1) : '0);
		end
	end

	// axi write path: address and data may come in either order
	logic        aw_have, w_have;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_go;
	assign wr_go = aw_have && w_have && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= FPB_RESP_OK;
		end else begin
			s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_have && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb; // strobes travel with their data beat
			end
			if (wr_go) begin
				aw_have      <= 1'b0;
				w_have       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr == FPB_REG_IRQ_MK || aw_addr == FPB_REG_LIMIT
					|| aw_addr == FPB_REG_PROT) ? FPB_RESP_OK : FPB_RESP_ERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// writable control registers; byte strobes honoured for mask and limit, the protect register ignores them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mk_reg <= '0;
			limit_reg  <= FPB_LIMIT_RST;
			prot_reg   <= '0;
		end else if (wr_go) begin
			if (aw_addr == FPB_REG_IRQ_MK && w_strb[0])
				irq_mk_reg <= w_data[1:0];
			if (aw_addr == FPB_REG_LIMIT) begin
				if (w_strb[0])
					limit_reg[7:0] <= w_data[7:0];
				if (w_strb[1])
					limit_reg[15:8] <= w_data[15:8];
			end
			if (aw_addr == FPB_REG_PROT)
				prot_reg <= w_data[PAGES-1:0];
		end
	end

	// axi read path; reading the interrupt status clears it, new events win
	logic [31:0] rd_val;
	always_comb begin
		rd_val = '0;
		case (s_axi_araddr)
			FPB_REG_STATUS: rd_val = {27'h0, buf_dirty_reg, buf_writable_reg, op_busy, op_status};
			FPB_REG_IRQ_ST: rd_val = {30'h0, irq_st_reg};
			FPB_REG_IRQ_MK: rd_val = {30'h0, irq_mk_reg};
			FPB_REG_PAGE:   rd_val = {{(32-PW){1'b0}}, buf_page_reg};
			FPB_REG_LIMIT:  rd_val = {16'h0, limit_reg};
			FPB_REG_PROT:   rd_val = {{(32-PAGES){1'b0}}, prot_reg};
			default:        rd_val = '0;
		endcase
	end

	logic rd_take;
	assign rd_take = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= FPB_RESP_OK;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_take;
			if (rd_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= (s_axi_araddr <= FPB_REG_PROT && s_axi_araddr[1:0] == 2'h0)
					? FPB_RESP_OK : FPB_RESP_ERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// sticky events: done and nonzero status
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_st_reg <= '0;
			irq       <= 1'b0;
		end else begin
			if (rd_take && s_axi_araddr == FPB_REG_IRQ_ST)
				irq_st_reg <= {op_done && op_status != FPB_ST_OK, op_done};
			else
				irq_st_reg <= irq_st_reg | {op_done && op_status != FPB_ST_OK, op_done};
			irq <= |(irq_st_reg & irq_mk_reg);
		end
	end

endmodule : fpb_top

// >>> testbench/fpb_flash_model.sv
// far-side model: flash array words and ecc flags for the load walk and reads
`timescale 1ns/1ps
module fpb_flash_model #(
	parameter int AW = 5
) (
	// clock
	input  wire logic          aclk,
	// array side
	input  wire logic [AW-1:0] array_addr,
	input  wire logic [1:0]    err_mode,
	output logic [31:0]        array_word,
	output logic               ecc_single,
	output logic               ecc_multi
);
	logic [AW-1:0] addr_q = '0;
	// word follows the address of the previous cycle, like the real array
	always_ff @(posedge aclk) begin
		addr_q <= array_addr;
	end
	assign array_word = 32'hc0de0000 | 32'(addr_q);
	// flags are active high; multi and single never raised together
	assign ecc_single = err_mode == 2'h1;
	assign ecc_multi  = err_mode == 2'h2;
endmodule : fpb_flash_model

// >>> testbench/fpb_top_asserts.sv
// checker: completion status and load timing seen at the ports of fpb_top
`timescale 1ns/1ps
module fpb_top_asserts
	import fpb_pkg::*;
(
	// clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// operation port
	input wire logic       op_start,
	input wire logic [2:0] op_code,
	input wire logic       page_unlock_load,
	input wire logic       ecc_single,
	input wire logic       ecc_multi,
	input wire logic [1:0] op_status,
	input wire logic       op_busy,
	input wire logic       op_done
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// a request counts only when idle, since a load pre-empts it
	wire idle_go = op_start && !page_unlock_load && !op_busy;
	wire rd_go   = idle_go && op_code == FPB_OP_READ;
	a_read_clean: assert property (rd_go && !ecc_single && !ecc_multi |=> op_done && op_status == FPB_ST_OK)
		else $error("clean read did not report success");
	a_read_single: assert property (rd_go && ecc_single && !ecc_multi |=> op_status == FPB_ST_ONE)
		else $error("corrected read error not reported");
	a_read_multi: assert property (rd_go && ecc_multi |=> op_status == FPB_ST_TWO)
		else $error("multiple read error not reported");
	a_op_answer: assert property (idle_go && op_code != FPB_OP_UNPROT && op_code <= FPB_OP_PROGRAM
		|=> op_done)
		else $error("operation gave no completion");
	a_done_pulse: assert property (op_done && !idle_go |=> !op_done)
		else $error("completion pulse longer than one cycle");
	a_status_hold: assert property (op_status != $past(op_status) |-> op_done)
		else $error("status changed without completion");
	a_load_time: assert property (page_unlock_load && !op_busy && !op_done |=> op_busy ##33 op_done)
		else $error("page load timing wrong");
	a_busy_end: assert property (op_busy && !op_done |=> op_busy || op_done)
		else $error("busy dropped before load finished");
	c_load: cover property (op_busy ##1 op_done);
	c_single: cover property (rd_go && ecc_single);
	c_three: cover property (op_done && op_status == FPB_ST_THREE);
endmodule : fpb_top_asserts

bind fpb_top fpb_top_asserts i_fpb_top_asserts (.aclk, .aresetn, .op_start, .op_code,
	.page_unlock_load, .ecc_single, .ecc_multi, .op_status, .op_busy, .op_done);

// >>> testbench/tb_top.sv
// testbench: operations, page loads and registers of fpb_top against a flash model
`timescale 1ns/1ps
module tb_top;
	import fpb_pkg::*;
	logic        aclk = '0, aresetn = '0, op_start = '0, page_unlock_load = '0, write_strobe = '0;
	logic [2:0]  op_code = '0;
	logic [3:0]  page_addr = '0, s_axi_wstrb = 4'hf;
	logic [4:0]  word_addr = '0, array_addr;
	logic [31:0] write_word_in = '0, array_word, read_word, s_axi_wdata = '0, s_axi_rdata, rd;
	logic [1:0]  err_mode = '0, op_status, s_axi_bresp, s_axi_rresp, rsp, m;
	logic        ecc_single, ecc_multi, op_busy, op_done, irq, s_axi_awready, s_axi_wready;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
	logic        s_axi_rready = '0, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] seed = 32'h2c;
	int          n_errors = 0, total_checks = 0;
	always #12.5 aclk = ~aclk;
	fpb_top i_fpb_top (.aclk, .aresetn, .op_start, .op_code, .page_addr, .word_addr,
		.page_unlock_load, .write_strobe, .write_word_in, .array_word, .ecc_single, .ecc_multi,
		.op_status, .op_busy, .op_done, .read_word, .array_addr, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
	fpb_flash_model i_fpb_flash_model (.aclk, .array_addr, .err_mode, .array_word, .ecc_single,
		.ecc_multi);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// expected read status: a multiple error outranks a corrected one
	function automatic logic [1:0] exp_rd(input logic [1:0] e);
		return (e == 2'h2) ? FPB_ST_TWO : (e == 2'h1) ? FPB_ST_ONE : FPB_ST_OK;
	endfunction : exp_rd
	task automatic chk_st(input logic [1:0] got, input logic [1:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t status %h expected %h", $time, got, exp);
		end
	endtask : chk_st
	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
		end
	endtask : chk_w
	// register write: address and data offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1 && n < 200);
		s_axi_bready <= 1'h0;
		rsp = s_axi_bresp;
		if (n >= 200) n_errors++;
	endtask : axw
	task automatic axr(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1 && n < 200);
		s_axi_rready <= 1'h0;
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		if (n >= 200) n_errors++;
	endtask : axr
	// immediate operation: result is seen one cycle after it is taken
	task automatic op(input logic [2:0] c, input logic [3:0] pg, input logic [1:0] exp);
		op_start <= 1'h1;
		op_code <= c;
		page_addr <= pg;
		@(posedge aclk);
		op_start <= 1'h0;
		@(negedge aclk);
		chk_w({31'h0, op_done}, 32'h1);
		chk_st(op_status, exp);
		@(posedge aclk);
	endtask : op
	// page load: one word per cycle, so completion lands a fixed time later
	task automatic load(input logic [3:0] pg, input logic [1:0] exp);
		int n;
		n = 0;
		page_unlock_load <= 1'h1;
		page_addr <= pg;
		@(posedge aclk);
		page_unlock_load <= 1'h0;
		do begin
			@(posedge aclk);
			n++;
		end while (op_done !== 1'h1 && n < 100);
		chk_w(32'(n), 32'h22);
		chk_st(op_status, exp);
	endtask : load
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (5000) @(posedge aclk);
		n_errors++;
		final_report();
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		chk_st(op_status, FPB_ST_OK);
		axr(FPB_REG_LIMIT);
		chk_w(rd, {16'h0, FPB_LIMIT_RST});
		axr(8'h40);
		chk_w({rd[29:0], rsp}, {30'h0, FPB_RESP_ERR});
		axw(FPB_REG_STATUS, 32'h0);
		chk_w({30'h0, rsp}, {30'h0, FPB_RESP_ERR});
		write_strobe <= 1'h1;
		@(posedge aclk);
		write_strobe <= 1'h0;
		axr(FPB_REG_STATUS);
		chk_w(rd & 32'h18, 32'h0);
		$display("test reset done");
		repeat (12) begin
			m = 2'(rnd() % 3);
			err_mode <= m;
			op(FPB_OP_READ, 4'(rnd()), exp_rd(m));
			chk_w(read_word, 32'hc0de0000);
		end
		err_mode <= 2'h0;
		repeat (3) @(posedge aclk);
		chk_st(op_status, exp_rd(m));
		$display("test reads done");
		axw(FPB_REG_PROT, 32'h20);
		chk_w({30'h0, rsp}, {30'h0, FPB_RESP_OK});
		op(FPB_OP_WRITE, 4'h5, FPB_ST_ONE);
		op(FPB_OP_ERASE, 4'h5, FPB_ST_ONE);
		op(FPB_OP_PROGRAM, 4'h2, FPB_ST_ONE);
		load(4'h2, FPB_ST_OK);
		axr(FPB_REG_PAGE);
		chk_w(rd, 32'h2);
		repeat (8) begin
			word_addr <= 5'(rnd());
			write_word_in <= rnd();
			write_strobe <= 1'h1;
			@(posedge aclk);
		end
		write_strobe <= 1'h0;
		axr(FPB_REG_STATUS);
		chk_w(rd & 32'h18, 32'h18);
		op(FPB_OP_WRITE, 4'h2, FPB_ST_OK);
		op(FPB_OP_WRITE, 4'h3, FPB_ST_THREE);
		axw(FPB_REG_LIMIT, 32'h0);
		op(FPB_OP_PROGRAM, 4'h2, FPB_ST_THREE);
		op(FPB_OP_ERASE, 4'h2, FPB_ST_THREE);
		axw(FPB_REG_LIMIT, 32'h2710);
		$display("test protect done");
		for (int i = 1; i < 3; i++) begin
			err_mode <= 2'(i);
			load(4'h7, exp_rd(2'(i)));
		end
		err_mode <= 2'h0;
		axr(FPB_REG_IRQ_ST);
		axw(FPB_REG_IRQ_MK, 32'h3);
		op(FPB_OP_READ, 4'h0, FPB_ST_OK);
		repeat (2) @(posedge aclk);
		chk_w({31'h0, irq}, 32'h1);
		axr(FPB_REG_IRQ_ST);
		chk_w(rd, 32'h1);
		repeat (2) @(posedge aclk);
		chk_w({31'h0, irq}, 32'h0);
		$display("test irq done");
		final_report();
	end
endmodule : tb_top
